// file: esf_slave_front.sv
// two-wire eeprom slave front end: link engine, crossings, write queue and array
`timescale 1ns/1ps
`default_nettype none
`include "esf_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - array of 64K or 32K bytes
// - fixed type nibble checked in select byte
// - device acks received bytes in ninth slot
// - all bits move on serial clock
// - data line open drain, only pulls low
// - select bits 3..1 match strap inputs
// - straps read as zero only in reset; floating pins are then sampled as is
// - write protect high blocks all writes
// - write protect reads low only in reset; a floating pin is then sampled as is
// - protected: select/address acked, data not
// - select bit 0: 1 read, 0 write
// - strap mismatch: no ack, back to standby
// - two address bytes, high first, acked
// - Stop after write starts programming cycle
module esf_slave_front
   import esf_pkg::*;
   #(
   parameter logic [3:0] DEV_TYPE_ID = 4'h6, // arbitrary value
   parameter logic BIG_DENSITY = 1'h1
   )
   (
   // system clock and reset
   input wire logic clk,
   input wire logic rst,
   // two-wire link
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // straps
   input wire logic strapSelBit0,
   input wire logic strapSelBit1,
   input wire logic strapSelBit2,
   input wire logic writeProtectIn,
   // status
   output logic progBusy
   );

   ////////////////////////////////////////////////////////////////////////////////
   // link domain state
   logic [1:0] lrstSh;
   logic linkRst;
   logic [2:0] sclSh, sdaSh, rdDoneSh;
   logic [1:0] wpSh, wrAckSh, busySh;
   logic [2:0] strapSh0, strapSh1;
   logic sclS, sdaS, wpS, busyS;
   logic startEv, stopEv, riseEv, fallEv, rdDoneEv, selMatch, wrIdle;
   logic [2:0] strapS;
   logic [15:0] addrMask, addrInc;
   esf_link_state_type stateReg, stateNext;
   logic [3:0] bitCntReg, bitCntNext;
   logic inAckReg, inAckNext, mSlotReg, mSlotNext, sdaOeReg, oeNext;
   logic [7:0] rxReg, rxNext, txReg, txNext;
   logic [15:0] addrReg, addrNext, rdAddrReg, rdAddrNext;
   logic wrPendReg, wrPendNext, wrTglReg, wrTglNext, rdTglReg, rdTglNext;
   logic commitTglReg, commitTglNext;
   esf_wr_word_type wrWordReg, wrWordNext;
   // system domain state
   logic [2:0] wrSh, rdSh, cmSh;
   logic wrEv, rdEv, cmEv;
   logic pushValidReg, pushValidNext, wrAckTglReg, wrAckNext;
   logic progBusyReg, busyNext, rdPendReg, rdDoneTglReg, rdDoneNext;
   logic [7:0] rdDataReg, rdDataNext, memRd;
   esf_wr_word_type pushDataReg, pushDataNext, popWord;

   esf_stream_if #(.WIDTH(`ESF_WORD_W)) pushIf ();
   esf_stream_if #(.WIDTH(`ESF_WORD_W)) popIf ();

   assign sdaOut = 1'h0; // never driven high, only the enable moves
   assign sdaOe = sdaOeReg;
   assign progBusy = progBusyReg;

   ////////////////////////////////////////////////////////////////////////////////
   // link reset release and pin synchronisers
   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         lrstSh <= `ESF_LRST_INIT;
      end else begin
         lrstSh <= {lrstSh[0], 1'h0};
      end
   end
   assign linkRst = lrstSh[1];

   // straps and protect settle low from reset; after it open pins are sampled as they are
   always_ff @(posedge linkClk or posedge linkRst) begin
      if (linkRst) begin
         // lines idle high, so no false edge right after reset
         sclSh <= `ESF_LINE_IDLE;
         sdaSh <= `ESF_LINE_IDLE;
         rdDoneSh <= 3'h0;
         wpSh <= 2'h0;
         wrAckSh <= 2'h0;
         busySh <= 2'h0;
         strapSh0 <= 3'h0;
         strapSh1 <= 3'h0;
      end else begin
         sclSh <= {sclSh[1:0], sclIn};
         sdaSh <= {sdaSh[1:0], sdaIn};
         rdDoneSh <= {rdDoneSh[1:0], rdDoneTglReg};
         wpSh <= {wpSh[0], writeProtectIn};
         wrAckSh <= {wrAckSh[0], wrAckTglReg};
         busySh <= {busySh[0], progBusyReg};
         strapSh0 <= {strapSelBit2, strapSelBit1, strapSelBit0};
         strapSh1 <= strapSh0;
      end
   end

   assign sclS = sclSh[1];
   assign sdaS = sdaSh[1];
   assign wpS = wpSh[1];
   assign busyS = busySh[1];
   assign strapS = strapSh1;
   assign startEv = sclS && sclSh[2] && sdaSh[2] && !sdaS;
   assign stopEv = sclS && sclSh[2] && !sdaSh[2] && sdaS;
   assign riseEv = sclS && !sclSh[2];
   assign fallEv = !sclS && sclSh[2];
   assign rdDoneEv = rdDoneSh[1] ^ rdDoneSh[2];
   assign wrIdle = (wrTglReg == wrAckSh[1]);
   assign addrMask = BIG_DENSITY ? `ESF_MASK_BIG : `ESF_MASK_SMALL;
   assign addrInc = (addrReg + 16'h1) & addrMask;
   // while programming the device ignores its select, so masters can poll
   assign selMatch = (rxReg[`ESF_SEL_TYPE] == DEV_TYPE_ID)
                     && (rxReg[`ESF_SEL_CE] == strapS) && !busyS;

   ////////////////////////////////////////////////////////////////////////////////
   // link engine
   always_comb begin
      stateNext = stateReg;
      bitCntNext = bitCntReg;
      inAckNext = inAckReg;
      mSlotNext = mSlotReg;
      rxNext = rxReg;
      txNext = txReg;
      addrNext = addrReg;
      oeNext = sdaOeReg;
      wrPendNext = wrPendReg;
      wrTglNext = wrTglReg;
      wrWordNext = wrWordReg;
      rdTglNext = rdTglReg;
      rdAddrNext = rdAddrReg;
      commitTglNext = commitTglReg;
      if (rdDoneEv) begin
         txNext = rdDataReg;
      end
      if (startEv) begin
         stateNext = ESF_DEVSEL;
         bitCntNext = 4'h0;
         inAckNext = 1'h0;
         mSlotNext = 1'h0;
         oeNext = 1'h0;
      end else if (stopEv) begin
         stateNext = ESF_IDLE;
         inAckNext = 1'h0;
         oeNext = 1'h0;
         if (wrPendReg) begin
            commitTglNext = !commitTglReg;
            wrPendNext = 1'h0;
         end
      end else if (stateReg != ESF_IDLE) begin
         if (riseEv) begin
            if (bitCntReg != `ESF_ACK_SLOT) begin
               rxNext = {rxReg[6:0], sdaS};
               txNext = {txReg[6:0], 1'h0};
               bitCntNext = bitCntReg + 4'h1;
            end else if (mSlotReg && sdaS) begin
               stateNext = ESF_IDLE; // master declined: wait for Stop
            end else if (stateReg == ESF_RDATA) begin
               // fetch ahead so the byte is ready before the slot ends
               rdTglNext = !rdTglReg;
               rdAddrNext = addrReg;
               addrNext = addrInc;
            end
         end else if (fallEv) begin
            if (inAckReg) begin
               inAckNext = 1'h0;
               mSlotNext = 1'h0;
               bitCntNext = 4'h0;
               oeNext = (stateReg == ESF_RDATA) && !txReg[7];
            end else if (bitCntReg == `ESF_ACK_SLOT) begin
               inAckNext = 1'h1;
               oeNext = 1'h0;
               unique case (stateReg)
                  ESF_IDLE: begin
                  end
                  ESF_DEVSEL: begin
                     if (selMatch) begin
                        oeNext = 1'h1;
                        stateNext = rxReg[`ESF_SEL_RW] ? ESF_RDATA : ESF_ADDRHI;
                     end else begin
                        stateNext = ESF_IDLE;
                     end
                  end
                  ESF_ADDRHI: begin
                     oeNext = 1'h1;
                     addrNext = {rxReg, addrReg[7:0]} & addrMask;
                     stateNext = ESF_ADDRLO;
                  end
                  ESF_ADDRLO: begin
                     oeNext = 1'h1;
                     addrNext = {addrReg[15:8], rxReg} & addrMask;
                     stateNext = ESF_WDATA;
                  end
                  ESF_WDATA: begin
                     // a full queue holds back the handshake, which refuses the byte
                     if (!wpS && wrIdle) begin
                        oeNext = 1'h1;
                        wrTglNext = !wrTglReg;
                        wrWordNext.addr = addrReg;
                        wrWordNext.data = rxReg;
                        addrNext = addrInc;
                        wrPendNext = 1'h1;
                     end
                  end
                  ESF_RDATA: begin
                     mSlotNext = 1'h1;
                  end
               endcase
            end else if (stateReg == ESF_RDATA) begin
               oeNext = !txReg[7];
            end
         end
      end
   end

   always_ff @(posedge linkClk or posedge linkRst) begin
      if (linkRst) begin
         stateReg <= ESF_IDLE;
         bitCntReg <= 4'h0;
         inAckReg <= 1'h0;
         mSlotReg <= 1'h0;
         rxReg <= 8'h0;
         txReg <= 8'h0;
         addrReg <= 16'h0;
         sdaOeReg <= 1'h0;
         wrPendReg <= 1'h0;
         wrTglReg <= 1'h0;
         wrWordReg <= '0;
         rdTglReg <= 1'h0;
         rdAddrReg <= 16'h0;
         commitTglReg <= 1'h0;
      end else begin
         stateReg <= stateNext;
         bitCntReg <= bitCntNext;
         inAckReg <= inAckNext;
         mSlotReg <= mSlotNext;
         rxReg <= rxNext;
         txReg <= txNext;
         addrReg <= addrNext;
         sdaOeReg <= oeNext;
         wrPendReg <= wrPendNext;
         wrTglReg <= wrTglNext;
         wrWordReg <= wrWordNext;
         rdTglReg <= rdTglNext;
         rdAddrReg <= rdAddrNext;
         commitTglReg <= commitTglNext;
      end
   end

   sequence ackEntry;
      fallEv && bitCntReg == `ESF_ACK_SLOT && !inAckReg && stateReg != ESF_IDLE;
   endsequence

   sel_match_a: assert property (@(posedge linkClk) disable iff (linkRst)
      ackEntry ##0 (stateReg == ESF_DEVSEL && selMatch) |=> sdaOeReg && inAckReg)
      else $error("matching select not acknowledged");
   sel_miss_a: assert property (@(posedge linkClk) disable iff (linkRst)
      ackEntry ##0 (stateReg == ESF_DEVSEL && !selMatch) |=> !sdaOeReg && stateReg == ESF_IDLE)
      else $error("foreign select acknowledged");
   strap_cmp_a: assert property (@(posedge linkClk) disable iff (linkRst)
      ackEntry ##0 (stateReg == ESF_DEVSEL && rxReg[`ESF_SEL_CE] != strapS) |=> !sdaOeReg)
      else $error("strap mismatch acknowledged");
   addr_ack_a: assert property (@(posedge linkClk) disable iff (linkRst)
      ackEntry ##0 (stateReg == ESF_ADDRHI) |=> sdaOeReg && stateReg == ESF_ADDRLO)
      else $error("high address byte not acknowledged");
   wp_nack_a: assert property (@(posedge linkClk) disable iff (linkRst)
      ackEntry ##0 (stateReg == ESF_WDATA && wpS) |=> !sdaOeReg && $stable(wrTglReg))
      else $error("protected data byte taken");
   ack_release_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (fallEv && inAckReg && stateReg != ESF_RDATA && stateReg != ESF_IDLE) |=> !sdaOeReg && bitCntReg == 4'h0)
      else $error("ack slot not released");
   stop_commit_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (stopEv && wrPendReg) |=> $changed(commitTglReg) && stateReg == ESF_IDLE && !wrPendReg)
      else $error("stop did not commit write");
   start_seen_a: assert property (@(posedge linkClk) disable iff (linkRst)
      startEv |=> stateReg == ESF_DEVSEL && bitCntReg == 4'h0 && !sdaOeReg)
      else $error("start not taken");
   bit_count_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (riseEv && !startEv && !stopEv && stateReg != ESF_IDLE && bitCntReg < `ESF_ACK_SLOT)
      |=> bitCntReg == $past(bitCntReg) + 4'h1)
      else $error("bit not counted on clock rise");

   ////////////////////////////////////////////////////////////////////////////////
   // system domain: crossings, write queue, programming and array
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrSh <= 3'h0;
         rdSh <= 3'h0;
         cmSh <= 3'h0;
      end else begin
         wrSh <= {wrSh[1:0], wrTglReg};
         rdSh <= {rdSh[1:0], rdTglReg};
         cmSh <= {cmSh[1:0], commitTglReg};
      end
   end
   assign wrEv = wrSh[1] ^ wrSh[2];
   assign rdEv = rdSh[1] ^ rdSh[2];
   assign cmEv = cmSh[1] ^ cmSh[2];

   assign pushIf.valid = pushValidReg;
   assign pushIf.data = pushDataReg;
   assign popIf.ready = progBusyReg; // queue drains only during programming
   assign popWord = popIf.data;

   always_comb begin
      pushValidNext = pushValidReg;
      pushDataNext = pushDataReg;
      wrAckNext = wrAckTglReg;
      busyNext = progBusyReg;
      if (pushValidReg && pushIf.ready) begin
         pushValidNext = 1'h0;
         wrAckNext = !wrAckTglReg;
      end
      if (wrEv) begin
         pushValidNext = 1'h1;
         pushDataNext = wrWordReg;
      end
      if (cmEv) begin
         busyNext = 1'h1;
      end else if (!popIf.valid && !pushValidReg && !wrEv) begin
         busyNext = 1'h0;
      end
      rdDataNext = rdPendReg ? memRd : rdDataReg;
      rdDoneNext = rdPendReg ? !rdDoneTglReg : rdDoneTglReg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pushValidReg <= 1'h0;
         pushDataReg <= '0;
         wrAckTglReg <= 1'h0;
         progBusyReg <= 1'h0;
         rdPendReg <= 1'h0;
         rdDataReg <= 8'h0;
         rdDoneTglReg <= 1'h0;
      end else begin
         pushValidReg <= pushValidNext;
         pushDataReg <= pushDataNext;
         wrAckTglReg <= wrAckNext;
         progBusyReg <= busyNext;
         rdPendReg <= rdEv;
         rdDataReg <= rdDataNext;
         rdDoneTglReg <= rdDoneNext;
      end
   end

   // a page longer than the queue plus the one word held in the push register is refused byte by byte, not wrapped
   esf_fifo #(.WIDTH(`ESF_WORD_W), .DEPTH(`ESF_FIFO_DEPTH)) writeQueue (
      .clk(clk),
      .rst(rst),
      .inSide(pushIf.snk),
      .outSide(popIf.src)
   );

   esf_mem array (
      .clk(clk),
      .wrEn(popIf.valid && popIf.ready),
      .wrAddr(popWord.addr),
      .wrData(popWord.data),
      .rdEn(rdEv),
      .rdAddr(rdAddrReg),
      .rdData(memRd)
   );

   sequence commitSeen;
      cmEv;
   endsequence

   busy_set_a: assert property (@(posedge clk) disable iff (rst)
      commitSeen |=> progBusyReg)
      else $error("commit did not start programming");
   rd_return_a: assert property (@(posedge clk) disable iff (rst)
      rdEv |-> ##2 (rdDoneTglReg != $past(rdDoneTglReg)))
      else $error("read data not returned");
endmodule : esf_slave_front
`default_nettype wire

// file: esf_defs.svh
// constants of the serial eeprom slave front end
`ifndef ESF_DEFS_SVH
`define ESF_DEFS_SVH
`define ESF_ADDR_W 16
`define ESF_DATA_W 8
`define ESF_WORD_W 24
`define ESF_MEM_DEPTH 65536
`define ESF_FIFO_DEPTH 32
`define ESF_ACK_SLOT 4'h8
`define ESF_MASK_BIG 16'hffff
`define ESF_MASK_SMALL 16'h7fff
`define ESF_SEL_TYPE 7:4
`define ESF_SEL_CE 3:1
`define ESF_SEL_RW 0
`define ESF_LRST_INIT 2'h3
`define ESF_LINE_IDLE 3'h7
`endif

// file: esf_pkg.sv
// types of the serial eeprom slave front end
`include "esf_defs.svh"
package esf_pkg;
   typedef enum logic [2:0] {
      ESF_IDLE,
      ESF_DEVSEL,
      ESF_ADDRHI,
      ESF_ADDRLO,
      ESF_WDATA,
      ESF_RDATA
   } esf_link_state_type;
   typedef struct packed {
      logic [`ESF_ADDR_W-1:0] addr;
      logic [`ESF_DATA_W-1:0] data;
   } esf_wr_word_type;
endpackage : esf_pkg

// file: esf_stream_if.sv
// valid/ready word stream between the front end and its write queue
`timescale 1ns/1ps
`default_nettype none
interface esf_stream_if #(parameter int WIDTH = 24) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : esf_stream_if
`default_nettype wire

// file: esf_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "esf_defs.svh"
module esf_fifo
   import esf_pkg::*;
   #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
   )
   (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill and drain sides
   esf_stream_if.snk inSide,
   esf_stream_if.src outSide
   );
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wrPtrReg, wrPtrNext, rdPtrReg, rdPtrNext;
   logic [PW:0] cntReg, cntNext;
   logic push, pop;

   assign inSide.ready = (cntReg != FULL_CNT);
   assign outSide.valid = (cntReg != '0);
   assign outSide.data = store[rdPtrReg];
   assign push = inSide.valid && inSide.ready;
   assign pop = outSide.valid && outSide.ready;

   always_comb begin
      wrPtrNext = push ? wrPtrReg + 1'b1 : wrPtrReg;
      rdPtrNext = pop ? rdPtrReg + 1'b1 : rdPtrReg;
      cntNext = cntReg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtrReg <= '0;
         rdPtrReg <= '0;
         cntReg <= '0;
      end else begin
         wrPtrReg <= wrPtrNext;
         rdPtrReg <= rdPtrNext;
         cntReg <= cntNext;
      end
   end

   // storage has no reset; only the pointers and the count say what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         store[wrPtrReg] <= inSide.data;
      end
   end
endmodule : esf_fifo
`default_nettype wire

// file: esf_mem.sv
// byte-wide storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "esf_defs.svh"
module esf_mem
   import esf_pkg::*;
   (
   // clock
   input wire logic clk,
   // write port
   input wire logic wrEn,
   input wire logic [`ESF_ADDR_W-1:0] wrAddr,
   input wire logic [`ESF_DATA_W-1:0] wrData,
   // read port
   input wire logic rdEn,
   input wire logic [`ESF_ADDR_W-1:0] rdAddr,
   output logic [`ESF_DATA_W-1:0] rdData
   );
   logic [`ESF_DATA_W-1:0] cells [`ESF_MEM_DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         cells[wrAddr] <= wrData;
      end
      if (rdEn) begin
         rdData <= cells[rdAddr];
      end
   end
endmodule : esf_mem
`default_nettype wire

// file: esf_bus_master.sv
// two-wire bus master model for the slave front end
`timescale 1ns/1ps
`default_nettype none
module esf_bus_master #(
   parameter int HALF = 1240
   )
   (
   // resolved data wire
   input wire logic sdaWire,
   // master drive
   output logic scl,
   output logic sdaLow
   );
   // a whole number of system clocks keeps edges off the sampling edge
   localparam int QTR = HALF / 2;
   initial begin
      scl = 1'h1;
      sdaLow = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one bit slot: data set while clock low, sampled at end of high phase
   task automatic bitSlot(input logic drvLow, output logic seen);
      sdaLow = drvLow;
      #QTR;
      scl = 1'h1;
      #HALF;
      seen = sdaWire;
      scl = 1'h0;
      #QTR;
   endtask : bitSlot
   // also serves as repeated start: data released before clock rises
   task automatic start();
      sdaLow = 1'h0;
      #QTR;
      scl = 1'h1;
      #HALF;
      sdaLow = 1'h1;
      #QTR;
      scl = 1'h0;
      #QTR;
   endtask : start
   task automatic stop();
      sdaLow = 1'h1;
      #QTR;
      scl = 1'h1;
      #HALF;
      sdaLow = 1'h0;
      #HALF;
   endtask : stop
   task automatic wrByte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(~b[i], s);
      end
      bitSlot(1'h0, s);
      acked = ~s;
   endtask : wrByte
   task automatic rdByte(input logic ackIt, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(1'h0, b[i]);
      end
      bitSlot(ackIt, s);
   endtask : rdByte
endmodule : esf_bus_master
`default_nettype wire

// file: esf_slave_front_tb.sv
// self-checking bench of the serial eeprom slave front end
`timescale 1ns/1ps
`default_nettype none
module esf_slave_front_tb;
   import esf_pkg::*;
   localparam logic [3:0] TID = 4'h9; // arbitrary type nibble
   localparam logic [2:0] STRAP = 3'h5;
   logic clk = 1'h0;
   logic linkClk = 1'h0;
   logic rst = 1'h1;
   logic wpIn = 1'h0;
   logic [2:0] strap = STRAP;
   logic sdaOut, sdaOe, progBusy, scl, sdaLow, sdaWire, ack;
   logic sawBusy = 1'h0;
   logic [15:0] rd;
   int error_cnt = 0;
   int n_compared = 0;
   // rows: expected ack, select byte
   logic [8:0] rows [4] = '{{1'h1, TID, STRAP, 1'h0}, {1'h0, TID, 3'h4, 1'h0},
      {1'h0, TID, 3'h1, 1'h0}, {1'h0, 4'h3, STRAP, 1'h0}};
   // pull-up wire: low if the master pulls, the device's level while enabled, else high
   assign sdaWire = !sdaLow && (sdaOe ? sdaOut : 1'h1);
   always #10 clk = ~clk;
   always #24 linkClk = ~linkClk;
   always @(posedge clk) begin
      if (progBusy === 1'h1) sawBusy = 1'h1;
   end
   esf_slave_front #(.DEV_TYPE_ID(TID), .BIG_DENSITY(1'h1)) i_dut (.clk(clk), .rst(rst), .linkClk(linkClk),
      .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapSelBit0(strap[0]),
      .strapSelBit1(strap[1]), .strapSelBit2(strap[2]), .writeProtectIn(wpIn), .progBusy(progBusy));
   esf_bus_master i_mst (.sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrAck(input logic [7:0] b, input logic expAck, input string what);
      i_mst.wrByte(b, ack);
      check(what, {15'h0, ack}, {15'h0, expAck});
   endtask : wrAck
   // select acked and both address bytes acked, high byte first
   task automatic setAddr(input logic [15:0] a);
      @(negedge clk);
      i_mst.start();
      wrAck({TID, STRAP, 1'h0}, 1'h1, "write select");
      wrAck(a[15:8], 1'h1, "addr hi");
      wrAck(a[7:0], 1'h1, "addr lo");
   endtask : setAddr
   task automatic readPair(input logic [15:0] a, output logic [15:0] d);
      setAddr(a);
      i_mst.start();
      wrAck({TID, STRAP, 1'h1}, 1'h1, "read select");
      i_mst.rdByte(1'h1, d[15:8]);
      i_mst.rdByte(1'h0, d[7:0]);
      i_mst.stop();
   endtask : readPair
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1_600_000;
      error_cnt++;
      $display("watchdog expired");
      conclude();
   end
   initial begin
      repeat (12) @(posedge clk);
      check("oe in reset", {15'h0, sdaOe}, 16'h0);
      check("busy in reset", {15'h0, progBusy}, 16'h0);
      @(negedge clk);
      rst = 1'h0;
      #1000;
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         i_mst.start();
         wrAck(rows[i][7:0], rows[i][8], "select row");
         i_mst.stop();
      end
      $display("select table done");
      sawBusy = 1'h0;
      setAddr(16'h1234);
      wrAck(8'ha5, 1'h1, "data 0");
      wrAck(8'h5a, 1'h1, "data 1");
      i_mst.stop();
      repeat (200) @(posedge clk);
      check("programmed", {15'h0, sawBusy}, 16'h1);
      check("busy end", {15'h0, progBusy}, 16'h0);
      check("open drain", {15'h0, sdaOut}, 16'h0);
      $display("write test done");
      readPair(16'h1234, rd);
      check("read pair", rd, 16'ha55a);
      $display("read test done");
      @(negedge clk);
      wpIn = 1'h1;
      sawBusy = 1'h0;
      setAddr(16'h1234);
      wrAck(8'h00, 1'h0, "protected data");
      wrAck(8'hff, 1'h0, "protected data");
      i_mst.stop();
      repeat (200) @(posedge clk);
      check("no program", {15'h0, sawBusy}, 16'h0);
      @(negedge clk);
      wpIn = 1'h0;
      readPair(16'h1234, rd);
      check("kept contents", rd, 16'ha55a);
      $display("protect test done");
      // reset in mid write: the pending byte must never be programmed
      sawBusy = 1'h0;
      setAddr(16'h0100);
      wrAck(8'h77, 1'h1, "data before reset");
      @(negedge clk);
      rst = 1'h1;
      repeat (12) @(negedge clk);
      check("oe in mid reset", {15'h0, sdaOe}, 16'h0);
      check("busy in mid reset", {15'h0, progBusy}, 16'h0);
      rst = 1'h0;
      #1000;
      i_mst.stop();
      repeat (200) @(posedge clk);
      check("no commit after reset", {15'h0, sawBusy}, 16'h0);
      @(negedge clk);
      i_mst.start();
      wrAck({TID, STRAP, 1'h0}, 1'h1, "select after reset");
      i_mst.stop();
      $display("mid reset test done");
      conclude();
   end
endmodule : esf_slave_front_tb
`default_nettype wire
